// ---- include/cwu_defines.vh ----
`ifndef CWU_DEFINES_VH
`define CWU_DEFINES_VH

// --------------------------------------------------
// register byte offsets
// --------------------------------------------------
`define CWU_OFS_CON0 12'h000
`define CWU_OFS_POL 12'h004
`define CWU_OFS_STEER 12'h008
`define CWU_OFS_AS0 12'h00C
`define CWU_OFS_AS1 12'h010
`define CWU_OFS_ISM 12'h014
`define CWU_OFS_CLK 12'h018
`define CWU_OFS_DBR 12'h01C
`define CWU_OFS_DBF 12'h020

// --------------------------------------------------
// decoder one-hot positions
// --------------------------------------------------
`define CWU_R_CON0 0
`define CWU_R_POL 1
`define CWU_R_STEER 2
`define CWU_R_AS0 3
`define CWU_R_AS1 4
`define CWU_R_ISM 5
`define CWU_R_CLK 6
`define CWU_R_DBR 7
`define CWU_R_DBF 8
`define CWU_NREG 9

// --------------------------------------------------
// field positions
// --------------------------------------------------
`define CWU_CON0_EN 7
`define CWU_CON0_LD 6
`define CWU_POL_IN 5
`define CWU_AS0_SHDN 7
`define CWU_AS0_REN 6
`define CWU_AS0_OVERRIDE_LEVEL_BD 4
`define CWU_AS0_OVERRIDE_LEVEL_AC 2
`define CWU_AS1_PIN 0
`define CWU_AS1_TMR 1
`define CWU_AS1_CMP1 2
`define CWU_AS1_CMP2 3
`define CWU_CLK_CS 0

// --------------------------------------------------
// reset values
// --------------------------------------------------
`define CWU_RST_AS0 8'h14
`define CWU_RST_DB 6'h00

// --------------------------------------------------
// mode and override codes
// --------------------------------------------------
`define CWU_MODE_ASTEER 3'h0
`define CWU_MODE_SSTEER 3'h1
`define CWU_MODE_FFB 3'h2
`define CWU_MODE_RFB 3'h3
`define CWU_MODE_HB 3'h4
`define CWU_MODE_PP 3'h5
`define CWU_OVR_ONE 2'h3
`define CWU_OVR_ZERO 2'h2
`define CWU_OVR_HIZ 2'h1
`define CWU_OVR_INACT 2'h0

`endif

// ---- logic/cwu_edge_det.v ----
`timescale 1ns/1ps
// --------------------------------------------------
// rising and falling event detector
// --------------------------------------------------
module cwu_edge_det (
  input wire sys_clk,
  input wire rst_n,
  input wire sig,
  output wire rise,
  output wire fall
);
  reg prev_ff;

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sig;
    end
  end

  assign rise = sig & ~prev_ff;
  assign fall = ~sig & prev_ff;
endmodule

// ---- logic/cwu_out_cell.v ----
`timescale 1ns/1ps
`include "cwu_defines.vh"
// --------------------------------------------------
// one output pin: override, polarity, enable
// --------------------------------------------------
module cwu_out_cell (
  input wire sys_clk,
  input wire rst_n,
  input wire en,
  input wire shut,
  input wire wave,
  input wire pol,
  input wire [1:0] ovr_code,
  output wire pin_o,
  output wire pin_oe
);
  reg lvl_ff;
  reg oe_ff;
  reg nxt_lvl;
  reg nxt_oe;

  always @* begin
    nxt_lvl = 1'b0;
    nxt_oe = 1'b0;
    if (shut) begin
      // polarity never alters the fixed override levels
      case (ovr_code)
        `CWU_OVR_ONE: begin
          nxt_lvl = 1'b1;
          nxt_oe = 1'b1;
        end
        `CWU_OVR_ZERO: begin
          nxt_lvl = 1'b0;
          nxt_oe = 1'b1;
        end
        `CWU_OVR_HIZ: begin
          nxt_lvl = 1'b0;
          nxt_oe = 1'b0;
        end
        default: begin
          nxt_lvl = pol;
          nxt_oe = 1'b1;
        end
      endcase
    end else if (en) begin
      nxt_lvl = wave ^ pol;
      nxt_oe = 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      lvl_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      lvl_ff <= nxt_lvl;
      oe_ff <= nxt_oe;
    end
  end

  assign pin_o = lvl_ff;
  assign pin_oe = oe_ff;
endmodule

// ---- logic/cwu_top.v ----
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "cwu_defines.vh"
// Behaviour
// R1 - steering modes route input to any output set
// R2 - steer bit 0 fixed level, 1 input data
// R3 - polarity applies only to steered outputs
// R4 - shutdown overrides only steered outputs
// R5 - mode 000 steer change takes effect immediately
// R6 - mode 001 steer change waits rising input
// R7 - software setting shutdown bit forces shutdown
// R8 - no auto-restart: shutdown holds while bit set
// R9 - auto-restart: bit self-clears, resume next rise
// R10 - selected fault input forces overrides, sets bit
// R11 - four active-low fault sources, individually enabled
// R12 - faults level sensed; clear blocked while active
// R13 - two override fields for B/D and A/C
// R14 - software clear only when no fault active
// R15 - overrides stay until first rise after clear
// R16 - auto-restart clears bit once faults gone
// R17 - generator runs from its own selected clock; here all logic runs on sys_clk and cs_ff only feeds osc_keep_awake and its register read-back
// R18 - keep fast oscillator awake when needed
// R19 - enable bit 7 turns generator on, reset 0
// R20 - load bit arms buffer transfer, self-clears
// R21 - software sets load only after enabling
// R22 - three-bit mode field selects operating mode
// R23 - software bring-up sequence ends with restart
// R24 - override codes: one, zero, float, inactive
// R25 - dead-band direct when disabled, buffered when enabled
// R26 - shutdown may be set while disabled
// R27 - reserved mode drives inactive levels
module cwu_top #(
  parameter NSRC = 16,
  parameter SELW = 4
) (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [NSRC-1:0] data_src,
  input wire src_active,
  input wire comparator_one_out,
  input wire comparator_two_out,
  input wire timer_postscale_out,
  input wire external_input_pin,
  output wire output_a,
  output wire output_b,
  output wire output_c,
  output wire output_d,
  output wire output_a_oe,
  output wire output_b_oe,
  output wire output_c_oe,
  output wire output_d_oe,
  output wire [5:0] db_rise_val,
  output wire [5:0] db_fall_val,
  output wire osc_keep_awake
);

  // --------------------------------------------------
  // address decode
  // --------------------------------------------------
  function [`CWU_NREG-1:0] cwu_dec;
    input [11:0] a;
    begin
      cwu_dec = {`CWU_NREG{1'b0}};
      if (a == `CWU_OFS_CON0) begin
        cwu_dec[`CWU_R_CON0] = 1'b1;
      end else if (a == `CWU_OFS_POL) begin
        cwu_dec[`CWU_R_POL] = 1'b1;
      end else if (a == `CWU_OFS_STEER) begin
        cwu_dec[`CWU_R_STEER] = 1'b1;
      end else if (a == `CWU_OFS_AS0) begin
        cwu_dec[`CWU_R_AS0] = 1'b1;
      end else if (a == `CWU_OFS_AS1) begin
        cwu_dec[`CWU_R_AS1] = 1'b1;
      end else if (a == `CWU_OFS_ISM) begin
        cwu_dec[`CWU_R_ISM] = 1'b1;
      end else if (a == `CWU_OFS_CLK) begin
        cwu_dec[`CWU_R_CLK] = 1'b1;
      end else if (a == `CWU_OFS_DBR) begin
        cwu_dec[`CWU_R_DBR] = 1'b1;
      end else if (a == `CWU_OFS_DBF) begin
        cwu_dec[`CWU_R_DBF] = 1'b1;
      end
    end
  endfunction
  // --------------------------------------------------
  // state, with the reset image of the shutdown control register
  // --------------------------------------------------
  localparam [7:0] RST_AS0 = `CWU_RST_AS0;
  reg en_ff;
  reg ld_ff;
  reg [2:0] mode_ff;
  reg [3:0] pol_ff;
  reg [3:0] steer_sel_ff;
  reg [3:0] steer_act_ff;
  reg shdn_ff;
  reg ren_ff;
  reg [1:0] override_level_bd_ff;
  reg [1:0] override_level_ac_ff;
  reg [3:0] as_en_ff;
  reg [SELW-1:0] ism_ff;
  reg cs_ff;
  reg [5:0] dbr_buf_ff;
  reg [5:0] dbf_buf_ff;
  reg [5:0] dbr_ff;
  reg [5:0] dbf_ff;
  reg ovr_ff;
  reg pp_ff;
  reg awake_ff;
  reg [31:0] prdata_ff;
  reg nxt_shdn;
  reg nxt_ld;
  reg nxt_ovr;
  reg [3:0] nxt_steer_sel;
  reg [3:0] nxt_steer_act;
  reg [3:0] wave;
  reg [3:0] shut_mask;
  reg [3:0] pol_mask;
  reg [31:0] rd_val;
  wire [`CWU_NREG-1:0] hit = cwu_dec(paddr);
  wire wr = psel & penable & pwrite;
  wire [`CWU_NREG-1:0] wsel = hit & {`CWU_NREG{wr}};
  wire data_in = data_src[ism_ff];
  wire rise;
  wire fall;
  wire [3:0] sd_raw;
  wire sd_act;
  wire shut;
  cwu_edge_det u_edge (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sig(data_in),
    .rise(rise),
    .fall(fall)
  );

  assign sd_raw[`CWU_AS1_PIN] = external_input_pin;
  assign sd_raw[`CWU_AS1_TMR] = timer_postscale_out;
  assign sd_raw[`CWU_AS1_CMP1] = comparator_one_out;
  assign sd_raw[`CWU_AS1_CMP2] = comparator_two_out;
  // level sensed and active low; a cleared enable masks a stuck source
  assign sd_act = |(~sd_raw & as_en_ff); // [R11] [R12]
  // fault path bypasses the status flop so outputs react a cycle sooner
  assign shut = sd_act | shdn_ff | ovr_ff; // [R10] [R15]

  // --------------------------------------------------
  // shutdown status and restart
  // --------------------------------------------------
  always @* begin
    nxt_shdn = shdn_ff;
    if (sd_act) begin
      nxt_shdn = 1'b1; // [R10]
    end else if (wsel[`CWU_R_AS0] & pwdata[`CWU_AS0_SHDN]) begin
      nxt_shdn = 1'b1; // [R7] [R26]
    end else if (wsel[`CWU_R_AS0]) begin
      nxt_shdn = 1'b0; // [R14] [R8]
    end else if (ren_ff) begin
      nxt_shdn = 1'b0; // [R9] [R16]
    end
  end
  always @* begin
    nxt_ovr = ovr_ff;
    if (shdn_ff | sd_act) begin
      nxt_ovr = 1'b1;
    end else if (rise) begin
      nxt_ovr = 1'b0; // [R15]
    end
  end
  always @* begin
    nxt_steer_sel = steer_sel_ff;
    if (wsel[`CWU_R_STEER]) begin
      nxt_steer_sel = pwdata[3:0];
    end
  end
  always @* begin
    nxt_steer_act = steer_act_ff;
    if (mode_ff == `CWU_MODE_ASTEER) begin
      nxt_steer_act = nxt_steer_sel; // [R5]
    end else if (rise) begin
      nxt_steer_act = steer_sel_ff; // [R6]
    end
  end
  always @* begin
    nxt_ld = ld_ff;
    // a load request with the module still off is dropped
    if (wsel[`CWU_R_CON0] & pwdata[`CWU_CON0_LD] & en_ff) begin
      nxt_ld = 1'b1; // [R20] [R21]
    end else if (fall) begin
      nxt_ld = 1'b0; // [R20]
    end
  end
  // --------------------------------------------------
  // waveform per mode, bit 0 is output a
  // --------------------------------------------------
  always @* begin
    wave = 4'h0;
    shut_mask = 4'hF;
    pol_mask = 4'hF;
    case (mode_ff)
      `CWU_MODE_ASTEER, `CWU_MODE_SSTEER: begin
        wave = steer_act_ff & {4{data_in}}; // [R1] [R2]
        shut_mask = steer_act_ff; // [R4]
        pol_mask = steer_act_ff; // [R3]
      end
      `CWU_MODE_FFB: begin
        wave = {data_in, 1'b0, 1'b0, 1'b1};
      end
      `CWU_MODE_RFB: begin
        wave = {1'b0, 1'b1, data_in, 1'b0};
      end
      `CWU_MODE_HB: begin
        wave = {~data_in, data_in, ~data_in, data_in};
      end
      `CWU_MODE_PP: begin
        wave = {data_in & pp_ff, data_in & ~pp_ff, data_in & pp_ff, data_in & ~pp_ff};
      end
      default: begin
        wave = 4'h0; // [R27] [R22]
      end
    endcase
  end
  // --------------------------------------------------
  // register file and sequencing
  // --------------------------------------------------
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      en_ff <= 1'b0;
      ld_ff <= 1'b0;
      mode_ff <= `CWU_MODE_ASTEER;
      pol_ff <= 4'h0;
      steer_sel_ff <= 4'h0;
      steer_act_ff <= 4'h0;
      shdn_ff <= RST_AS0[`CWU_AS0_SHDN];
      ren_ff <= RST_AS0[`CWU_AS0_REN];
      override_level_bd_ff <= RST_AS0[`CWU_AS0_OVERRIDE_LEVEL_BD+1:`CWU_AS0_OVERRIDE_LEVEL_BD];
      override_level_ac_ff <= RST_AS0[`CWU_AS0_OVERRIDE_LEVEL_AC+1:`CWU_AS0_OVERRIDE_LEVEL_AC];
      as_en_ff <= 4'h0;
      ism_ff <= {SELW{1'b0}};
      cs_ff <= 1'b0;
      dbr_buf_ff <= `CWU_RST_DB;
      dbf_buf_ff <= `CWU_RST_DB;
      dbr_ff <= `CWU_RST_DB;
      dbf_ff <= `CWU_RST_DB;
      ovr_ff <= 1'b0;
      pp_ff <= 1'b0;
      awake_ff <= 1'b0;
    end else begin
      shdn_ff <= nxt_shdn;
      ovr_ff <= nxt_ovr;
      ld_ff <= nxt_ld;
      steer_sel_ff <= nxt_steer_sel;
      steer_act_ff <= nxt_steer_act;
      if (wsel[`CWU_R_CON0]) begin
        en_ff <= pwdata[`CWU_CON0_EN]; // [R19]
        mode_ff <= pwdata[2:0]; // [R22]
      end
      if (wsel[`CWU_R_POL]) begin
        pol_ff <= pwdata[3:0];
      end
      if (wsel[`CWU_R_AS0]) begin
        ren_ff <= pwdata[`CWU_AS0_REN];
        override_level_bd_ff <= pwdata[`CWU_AS0_OVERRIDE_LEVEL_BD+1:`CWU_AS0_OVERRIDE_LEVEL_BD]; // [R13]
        override_level_ac_ff <= pwdata[`CWU_AS0_OVERRIDE_LEVEL_AC+1:`CWU_AS0_OVERRIDE_LEVEL_AC]; // [R13]
      end
      if (wsel[`CWU_R_AS1]) begin
        as_en_ff <= pwdata[3:0]; // [R11]
      end
      if (wsel[`CWU_R_ISM]) begin
        ism_ff <= pwdata[SELW-1:0];
      end
      if (wsel[`CWU_R_CLK]) begin
        cs_ff <= pwdata[`CWU_CLK_CS];
      end
      if (wsel[`CWU_R_DBR]) begin
        dbr_buf_ff <= pwdata[5:0];
      end
      if (wsel[`CWU_R_DBF]) begin
        dbf_buf_ff <= pwdata[5:0];
      end
      if (wsel[`CWU_R_DBR] & ~en_ff) begin
        dbr_ff <= pwdata[5:0]; // [R25]
      end else if (en_ff & ld_ff & fall) begin
        dbr_ff <= dbr_buf_ff; // [R25] [R20]
      end
      if (wsel[`CWU_R_DBF] & ~en_ff) begin
        dbf_ff <= pwdata[5:0]; // [R25]
      end else if (en_ff & ld_ff & fall) begin
        dbf_ff <= dbf_buf_ff; // [R25] [R20]
      end
      // sequencer restarts on disable or shutdown; first pulse goes to a and c
      if (~en_ff | shut) begin
        pp_ff <= 1'b0;
      end else if (fall) begin
        pp_ff <= ~pp_ff;
      end
      // oscillator request covers the case where the cpu sleeps
      awake_ff <= en_ff & src_active & cs_ff; // [R17] [R18]
    end
  end
  // --------------------------------------------------
  // apb read path, captured in the setup cycle
  // --------------------------------------------------
  always @* begin
    rd_val = 32'h0000_0000;
    if (hit[`CWU_R_CON0]) begin
      rd_val[7:0] = {en_ff, ld_ff, 3'h0, mode_ff};
    end else if (hit[`CWU_R_POL]) begin
      rd_val[7:0] = {2'h0, data_in, 1'b0, pol_ff};
    end else if (hit[`CWU_R_STEER]) begin
      rd_val[3:0] = steer_sel_ff;
    end else if (hit[`CWU_R_AS0]) begin
      rd_val[7:0] = {shdn_ff, ren_ff, override_level_bd_ff, override_level_ac_ff, 2'h0};
    end else if (hit[`CWU_R_AS1]) begin
      rd_val[3:0] = as_en_ff;
    end else if (hit[`CWU_R_ISM]) begin
      rd_val[SELW-1:0] = ism_ff;
    end else if (hit[`CWU_R_CLK]) begin
      rd_val[0] = cs_ff;
    end else if (hit[`CWU_R_DBR]) begin
      rd_val[5:0] = dbr_buf_ff;
    end else if (hit[`CWU_R_DBF]) begin
      rd_val[5:0] = dbf_buf_ff;
    end
  end
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata_ff <= rd_val;
    end
  end
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(|hit);
  // --------------------------------------------------
  // output stage
  // --------------------------------------------------
  wire [3:0] pin_o;
  wire [3:0] pin_oe;
  wire [7:0] ovr_codes = {override_level_bd_ff, override_level_ac_ff, override_level_bd_ff, override_level_ac_ff};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_out
      cwu_out_cell u_cell (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .en(en_ff),
        .shut(shut & shut_mask[gi]), // [R4] [R24]
        .wave(wave[gi]),
        .pol(pol_ff[gi] & pol_mask[gi]), // [R3]
        .ovr_code(ovr_codes[2*gi+1:2*gi]), // [R13] [R24]
        .pin_o(pin_o[gi]),
        .pin_oe(pin_oe[gi])
      );
    end
  endgenerate
  assign {output_d, output_c, output_b, output_a} = pin_o;
  assign {output_d_oe, output_c_oe, output_b_oe, output_a_oe} = pin_oe;
  assign db_rise_val = dbr_ff;
  assign db_fall_val = dbf_ff;
  assign osc_keep_awake = awake_ff;
endmodule

// ---- verification/cwu_switch_model.sv ----
`timescale 1ns/1ps
// ----
// power switch stage seen through the four pins
// ----
module cwu_switch_model (
  input wire sys_clk,
  input wire [3:0] pin_o,
  input wire [3:0] pin_oe,
  output wire [3:0] gate
);
  reg [3:0] last_ff = 4'h0;
  // no pull on the gates: a released pin toggles each cycle so it is never mistaken for a level
  assign gate = (pin_o & pin_oe) | (~last_ff & ~pin_oe);
  always @(posedge sys_clk) begin
    last_ff <= gate;
  end
endmodule

// ---- verification/cwu_top_properties.sv ----
`timescale 1ns/1ps
// ----
// pin and register properties
// ----
module cwu_top_properties (
  input wire sys_clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire src_active,
  input wire comparator_one_out,
  input wire comparator_two_out,
  input wire timer_postscale_out,
  input wire external_input_pin,
  input wire output_a,
  input wire output_b,
  input wire output_c,
  input wire output_d,
  input wire output_a_oe,
  input wire output_b_oe,
  input wire output_c_oe,
  input wire [5:0] db_rise_val,
  input wire [5:0] db_fall_val,
  input wire osc_keep_awake
);
  reg [7:0] con_ff, pol_ff, str_ff, as0_ff, as1_ff, clk_ff;
  reg [5:0] dbw_ff;
  reg [5:0] dbfw_ff;
  wire wr = psel & penable & pwrite;
  // shadow copies of what software writes, six bits for each dead-band register and none for input select; hardware changes to status bits are not mirrored
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      con_ff <= 8'h00;
      pol_ff <= 8'h00;
      str_ff <= 8'h00;
      as0_ff <= 8'h14;
      as1_ff <= 8'h00;
      clk_ff <= 8'h00;
      dbw_ff <= 6'h00;
      dbfw_ff <= 6'h00;
    end else if (wr) begin
      case (paddr)
        12'h000: con_ff <= pwdata[7:0];
        12'h004: pol_ff <= pwdata[7:0];
        12'h008: str_ff <= pwdata[7:0];
        12'h00C: as0_ff <= pwdata[7:0];
        12'h010: as1_ff <= pwdata[7:0];
        12'h018: clk_ff <= pwdata[7:0];
        12'h01C: dbw_ff <= pwdata[5:0];
        12'h020: dbfw_ff <= pwdata[5:0];
        default: ;
      endcase
    end
  end
  wire fault = |(as1_ff[3:0] & ~{comparator_two_out, comparator_one_out, timer_postscale_out, external_input_pin});
  // mode 001 defers steering, so its shadow steer bits are not trusted
  wire [3:0] hit = (con_ff[2:1] != 2'h0) ? 4'hF : (con_ff[0] ? 4'h0 : str_ff[3:0]);
  wire awake_c = con_ff[7] & src_active & clk_ff[0];
  chk_ovr_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault && as0_ff[3:2] == 2'h3 && hit[0] |=> output_a && output_a_oe) else $error("output_a not at override one");
  chk_ovr_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault && as0_ff[5:4] == 2'h2 && hit[1] |=> !output_b && output_b_oe) else $error("output_b not at override zero");
  chk_ovr_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault && as0_ff[3:2] == 2'h1 && hit[2] |=> !output_c_oe) else $error("output_c still driven");
  chk_ovr_inact: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fault && as0_ff[5:4] == 2'h0 && hit[3] |=> output_d == pol_ff[3]) else $error("output_d not inactive");
  chk_sw_shut: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && paddr == 12'h00C && pwdata[7:6] == 2'h2 && pwdata[3:2] == 2'h3 && hit[0]
    |-> ##2 (output_a && output_a_oe) [*3]) else $error("software shutdown not held");
  chk_clear_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    psel && penable && !pwrite && paddr == 12'h00C && fault && $past(fault) && $past(fault, 2)
    |-> prdata[7]) else $error("shutdown bit low during fault");
  chk_unsteered_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    con_ff[7] && con_ff[2:0] == 3'h0 && !str_ff[1] && $stable(str_ff) && $stable(con_ff) |=> !output_b)
    else $error("unsteered output_b not low");
  chk_osc_awake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    osc_keep_awake == $past(awake_c)) else $error("oscillator keep-awake wrong");
  chk_db_direct: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && paddr == 12'h01C && !con_ff[7] |-> ##[1:2] db_rise_val == dbw_ff) else $error("dead-band not loaded");
  chk_db_fall_direct: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr && paddr == 12'h020 && !con_ff[7] |-> ##[1:2] db_fall_val == dbfw_ff) else $error("falling dead-band not loaded");
endmodule

bind cwu_top cwu_top_properties u_props (.*);

// ---- verification/waveform_steering_shutdown_tb_top.sv ----
`timescale 1ns/1ps
// ----
// bench
// ----
module waveform_steering_shutdown_tb_top;
  reg sys_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, din = 1'b0, src_active = 1'b1;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [14:0] rnd = 15'h0;
  reg [3:0] flt_n = 4'hF;
  reg [32:0] rd_q[$];
  reg [7:0] pin_q[$];
  reg [7:0] v;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [3:0] pin_o, pin_oe, gate;
  integer n_mismatch = 0, cmp_count = 0, seed = 32'hCBC2, i;
  localparam [14:0] MC = {3'h7, 3'h6, 3'h4, 3'h3, 3'h2};
  localparam [19:0] ME = 20'h00569;
  cwu_top #(.NSRC(16), .SELW(4)) DUT (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .data_src({rnd, din}), .src_active(src_active), .comparator_one_out(flt_n[2]),
    .comparator_two_out(flt_n[3]), .timer_postscale_out(flt_n[1]), .external_input_pin(flt_n[0]),
    .output_a(pin_o[0]), .output_b(pin_o[1]), .output_c(pin_o[2]), .output_d(pin_o[3]),
    .output_a_oe(pin_oe[0]), .output_b_oe(pin_oe[1]), .output_c_oe(pin_oe[2]), .output_d_oe(pin_oe[3]),
    .db_rise_val(), .db_fall_val(), .osc_keep_awake());
  cwu_switch_model u_sw (.sys_clk(sys_clk), .pin_o(pin_o), .pin_oe(pin_oe), .gate(gate));
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // unselected candidate inputs wander, so a wrong source select shows up
  always @(posedge sys_clk) begin
    rnd <= 15'($random(seed));
  end
  task give_verdict;
    begin
      if (n_mismatch == 0 && cmp_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task cmp_rd(input reg [32:0] e);
    begin
      cmp_count = cmp_count + 1;
      if ({pslverr, prdata} !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value apb read expected %h seen %h", e, {pslverr, prdata});
      end
    end
  endtask
  task cmp_pin(input reg [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if ({pin_oe, gate & e[7:4]} !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value pins expected %h seen %h", e, {pin_oe, gate});
      end
    end
  endtask
  // read data is taken at the completing edge, pin levels mid-cycle once settled
  always @(posedge sys_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && rd_q.size() > 0) begin
      cmp_rd(rd_q.pop_front());
    end
  end
  always @(negedge sys_clk) begin
    if (pin_q.size() > 0) begin
      cmp_pin(pin_q.pop_front());
    end
  end
  task step(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
    end
  endtask
  task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) begin
        @(posedge sys_clk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input reg [11:0] a, input reg [7:0] d);
    begin
      apb(1'b1, a, {24'h0, d});
    end
  endtask
  task rd(input reg [11:0] a, input reg [7:0] e);
    begin
      rd_q.push_back({25'h0, e});
      apb(1'b0, a, 32'h0);
    end
  endtask
  task pins(input reg [3:0] oe, input reg [3:0] lvl);
    begin
      pin_q.push_back({oe, lvl & oe});
    end
  endtask
  task pulse;
    begin
      din <= 1'b0;
      step(3);
      din <= 1'b1;
      step(3);
    end
  endtask
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
  initial begin
    step(20);
    rst_n <= 1'b1;
    rd(12'h000, 8'h00);
    rd(12'h00C, 8'h14);
    rd_q.push_back({1'b1, 32'h0});
    apb(1'b0, 12'h040, 32'h0);
    wr(12'h01C, 8'h2A);
    wr(12'h020, 8'h15);
    wr(12'h008, 8'h0F);
    wr(12'h010, 8'h01);
    wr(12'h00C, 8'hAC);
    step(2);
    pins(4'hF, 4'h5);
    wr(12'h018, 8'h01);
    wr(12'h000, 8'h80);
    wr(12'h000, 8'hC0);
    rd(12'h000, 8'hC0);
    pulse;
    din <= 1'b0;
    step(3);
    rd(12'h000, 8'h80);
    pins(4'hF, 4'h5);
    wr(12'h00C, 8'h2C);
    step(2);
    pins(4'hF, 4'h5);
    pulse;
    pins(4'hF, 4'hF);
    wr(12'h008, 8'h05);
    step(2);
    pins(4'hF, 4'h5);
    wr(12'h004, 8'h0F);
    step(2);
    pins(4'hF, 4'h0);
    din <= 1'b0;
    step(3);
    pins(4'hF, 4'h5);
    wr(12'h004, 8'h00);
    wr(12'h000, 8'h81);
    din <= 1'b1;
    step(3);
    rd(12'h004, 8'h20);
    wr(12'h008, 8'h0F);
    step(2);
    pins(4'hF, 4'h5);
    pulse;
    pins(4'hF, 4'hF);
    wr(12'h000, 8'h85);
    for (i = 0; i < 5; i = i + 1) begin
      wr(12'h000, {5'h10, MC[3*i +: 3]});
      pulse;
      pins(4'hF, ME[4*i +: 4]);
    end
    wr(12'h000, 8'h80);
    for (i = 0; i < 4; i = i + 1) begin
      v = {2'h0, i[1:0], i[1:0], 2'h0};
      wr(12'h010, 8'h01 << i);
      wr(12'h00C, v);
      flt_n[i] <= 1'b0;
      step(2);
      pins((i == 1) ? 4'h0 : 4'hF, (i == 3) ? 4'hF : 4'h0);
      rd(12'h00C, v | 8'h80);
      wr(12'h00C, v);
      rd(12'h00C, v | 8'h80);
      flt_n[i] <= 1'b1;
      step(2);
      wr(12'h00C, v);
      rd(12'h00C, v);
      pulse;
      pins(4'hF, 4'hF);
    end
    wr(12'h00C, 8'hCC);
    step(2);
    pins(4'hF, 4'h5);
    pulse;
    rd(12'h00C, 8'h4C);
    pins(4'hF, 4'hF);
    flt_n[3] <= 1'b0;
    rd(12'h00C, 8'hCC);
    flt_n[3] <= 1'b1;
    src_active <= 1'b0;
    step(3);
    src_active <= 1'b1;
    rd(12'h00C, 8'h4C);
    step(3);
    give_verdict;
  end
endmodule
